//--- lcsd_divider.sv
// Sequential restoring divider giving num/den as a fixed-point fraction
`timescale 1ns/10ps
module lcsd_divider #(
  parameter int NUM_W = 20,
  parameter int Q_W   = 12
) (
  input  wire logic             clk_in,
  input  wire logic             sys_rst_in,
  input  wire logic             start_in,
  input  wire logic [NUM_W-1:0] num_in,
  input  wire logic [NUM_W-1:0] den_in,
  output logic                  done_out,
  output logic [Q_W:0]          quotient_out
);
  import lcsd_pkg::*;
  localparam logic [7:0] STEP_LAST = 8'(Q_W);

  logic [NUM_W:0]   rem;
  logic [NUM_W:0]   rem_left;
  logic [NUM_W-1:0] den;
  logic [Q_W:0]     q;
  logic [7:0]       step;
  logic             busy;
  logic             take;

  assign take     = rem >= {1'b0, den};
  assign rem_left = take ? rem - {1'b0, den} : rem;

  // One quotient bit per cycle keeps the area small; a new start restarts it
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      rem          <= '0;
      den          <= '0;
      q            <= '0;
      step         <= 8'h00;
      busy         <= 1'b0;
      done_out     <= 1'b0;
      quotient_out <= '0;
    end else begin
      done_out <= 1'b0;
      if (start_in) begin
        rem  <= {1'b0, num_in};
        den  <= den_in;
        step <= 8'h00;
        busy <= 1'b1;
      end else if (busy) begin
        q    <= {q[Q_W-1:0], take};
        rem  <= {rem_left[NUM_W-1:0], 1'b0};
        step <= step + 8'h01;
        if (step == STEP_LAST) begin
          busy         <= 1'b0;
          done_out     <= 1'b1;
          quotient_out <= {q[Q_W-1:0], take};
        end
      end
    end
  end
endmodule : lcsd_divider

//--- lcsd_far_side_model.sv
// Dimming source and power stage model facing the setpoint block
`timescale 1ns/10ps
module lcsd_far_side_model
  import lcsd_pkg::*;
(
  input  wire logic              clk_in,
  input  wire logic              gate_in,
  input  wire logic [7:0]        period_in,
  input  wire logic [7:0]        high_in,
  input  wire logic              level_in,
  input  wire logic              limit_en_in,
  input  wire logic              short_en_in,
  input  wire logic              aux_ok_in,
  output logic                   pwm_out,
  output lcsd_pkg::lcsd_pin_type pins_out
);
  logic [7:0] phase;

  initial begin
    phase = 8'h00;
    pwm_out = 1'b1;
    pins_out = '0;
  end

  // Zero period means a static level, as an open or held pin
  always @(negedge clk_in) begin
    phase <= (phase + 8'h01 >= period_in) ? 8'h00 : phase + 8'h01;
    pwm_out <= (period_in == 8'h00) ? level_in : (phase < high_in);
    // Sense crosses the limit only while the switch conducts
    pins_out.over_limit <= limit_en_in & gate_in;
    pins_out.over_short <= short_en_in;
    pins_out.aux_above <= aux_ok_in;
  end
endmodule : lcsd_far_side_model

//--- lcsd_pkg.sv
// Shared constants, timing counts and carrier types for the LED current setpoint block
package lcsd_pkg;
  localparam int CLK_PERIOD_NS    = 100;
  localparam int MS_NS            = 1000000;
  localparam int TICK_PERIOD_NS   = 1000000;
  localparam int TICK_CYCLES      = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int TICK_MS          = TICK_PERIOD_NS / MS_NS;
  localparam int UVP_TIME_MS      = 90;
  localparam int PWM_OFF_TIME_MS  = 25;
  localparam int RECOVERY_TIME_MS = 4000;
  localparam logic [11:0] UVP_TICKS      = 12'(UVP_TIME_MS / TICK_MS);
  localparam logic [11:0] PWM_OFF_TICKS  = 12'(PWM_OFF_TIME_MS / TICK_MS);
  localparam logic [11:0] RECOVERY_TICKS = 12'(RECOVERY_TIME_MS / TICK_MS);
  localparam int SHORT_BLANK_NS = 200;
  localparam logic [3:0] SHORT_BLANK_CYCLES = 4'((SHORT_BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] STARTUP_STEP_CYCLES = 4'h8;
  localparam int CODE_W    = 10;
  localparam int REF_W     = 13;
  localparam int FRAC_W    = 12;
  localparam int INT_W     = 14;
  localparam int PWM_CNT_W = 20;
  localparam int ACC_SHIFT = 17;
  localparam int FILTER_K  = 3;
  localparam logic [REF_W-1:0]  REF_FULL       = 13'h1000;
  localparam logic [REF_W-1:0]  DUTY_FULL_MIN  = 13'h0f34;
  localparam logic [REF_W-1:0]  ANALOG_DIM_INPUT_FLOOR     = 13'h0015;
  localparam logic [CODE_W-1:0] ANALOG_DIM_INPUT_EN_CODE   = 10'h040;
  localparam logic [CODE_W-1:0] ANALOG_DIM_INPUT_MIN_CODE  = 10'h050;
  localparam logic [CODE_W-1:0] ANALOG_DIM_INPUT_FULL_CODE = 10'h300;
  localparam logic [11:0]       ANALOG_DIM_INPUT_SCALE     = 12'h556;
  localparam logic [CODE_W-1:0] COMP_ZERO_CODE = 10'h07b;
  localparam logic [CODE_W-1:0] COMP_FULL_CODE = 10'h332;
  localparam logic [11:0]       COMP_SCALE     = 12'h5e4;
  localparam logic [2:0]        SHORT_PULSES   = 3'h4;
  localparam logic [INT_W-1:0]  INT_MAX        = 14'h3fff;

  typedef struct packed {
    logic over_limit;
    logic over_short;
    logic aux_above;
  } lcsd_pin_type;

  typedef struct packed {
    logic [CODE_W-1:0] analog_dim_input;
    logic [CODE_W-1:0] comp;
    logic [CODE_W-1:0] line;
    logic [CODE_W-1:0] cs;
  } lcsd_codes_type;

  typedef struct packed {
    logic fault_active;
    logic uvp_fault;
    logic short_fault;
    logic pwm_disabled;
    logic analog_dim_input_disabled;
    logic startup;
  } lcsd_status_type;

  typedef enum logic [1:0] {ST_STARTUP, ST_RUN, ST_FAULT} lcsd_state_type;
endpackage : lcsd_pkg

//--- lcsd_setpoint_core.sv
// Current setpoint, dimming measurement, gate control and protections of the LED controller
`timescale 1ns/10ps
// How it works
// RQ1: Setpoint is full scale unless CV active, analog dim low, or duty below 95%.
// RQ2: Compensation level at or above 4 V gives full scale; below 0.6 V gives zero.
// RQ3: Line-shaped reference is trimmed each half line so its average equals setpoint.
// RQ4: Gate on-time ends when current sense reaches the shaped reference.
// RQ5: At startup the integrator ramps until the power-factor reference reaches setpoint.
// RQ6: Integrator is cleared on cold start and on restart after a fault.
// RQ7: A plain supply hiccup without self-supply keeps the integrator value.
// RQ8: Aux winding not above 1 V within 90 ms of operation is a fault.
// RQ9: Sense above the peak limit ends the gate pulse for this cycle.
// RQ10: A second comparator at 140% limit is watched after a shorter blanking.
// RQ11: Four consecutive pulses over the short threshold shut down into auto-recovery.
// RQ12: Two counters measure PWM dim high time and period on the fast clock.
// RQ13: A divider forms high time over period and sets the setpoint.
// RQ14: The divider result is smoothed before use.
// RQ15: An open PWM dim input gives full current.
// RQ16: PWM dim low for over 25 ms disables the controller.
// RQ17: Analog dim code sets current proportionally, full scale at full level.
// RQ18: Analog dim below minimum clamps the setpoint to 0.5%.
// RQ19: Analog dim below enable level suppresses all gate pulses.
// RQ20: With both dim inputs the setpoint is their product.
// RQ21: Square curve option squares the dimming level.
// RQ22: Auto-recovery stops switching about 4 s before restarting.
// RQ23: No PWM edge before counter saturation means a static 100% or 0% level.
module lcsd_setpoint_core #(
  parameter int TICK_LEN = lcsd_pkg::TICK_CYCLES
) (
  input  wire logic                     clk_in,
  input  wire logic                     sys_rst_in,
  input  wire logic                     pwm_dim_input_in,
  input  wire lcsd_pkg::lcsd_pin_type   cmp_pins_in,
  input  wire lcsd_pkg::lcsd_codes_type codes_in,
  input  wire logic                     switch_start_in,
  input  wire logic                     half_line_in,
  input  wire logic                     supply_restart_in,
  input  wire logic                     dss_option_in,
  input  wire logic                     square_curve_in,
  output logic                          gate_drive_output_out,
  output logic [lcsd_pkg::REF_W-1:0]    current_setpoint_ref_out,
  output lcsd_pkg::lcsd_status_type     status_out
);
  import lcsd_pkg::*;

  // Pin synchronisers: pwm level plus the three analog comparator outputs
  logic [3:0]   pin_meta;
  logic [3:0]   pin_sync;
  logic         pwm_level;
  lcsd_pin_type cmp;
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      // Open dim pin idles high, so no false rise follows reset
      pin_meta <= 4'h8;
      pin_sync <= 4'h8;
    end else begin
      pin_meta <= {pwm_dim_input_in, cmp_pins_in};
      pin_sync <= pin_meta;
    end
  end
  assign pwm_level = pin_sync[3];
  assign cmp       = lcsd_pin_type'(pin_sync[2:0]);

  // Millisecond enable
  logic [23:0] tick_cnt;
  logic        tick;
  assign tick = tick_cnt == 24'(TICK_LEN - 1);
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || tick) begin
      tick_cnt <= 24'h000000;
    end else begin
      tick_cnt <= tick_cnt + 24'h000001;
    end
  end

  // PWM dim duty measurement
  logic                 pwm_prev;
  logic                 seen_rise;
  logic [PWM_CNT_W-1:0] hi_cnt;
  logic [PWM_CNT_W-1:0] per_cnt;
  logic                 pwm_rise;
  logic                 per_sat;
  logic                 div_done;
  logic [REF_W-1:0]     div_q;
  logic                 duty_valid;
  logic [REF_W-1:0]     duty_value;
  logic [REF_W-1:0]     pwm_filt;
  logic [REF_W-1:0]     pwm_ratio;
  assign pwm_rise = pwm_level && !pwm_prev;
  assign per_sat  = &per_cnt;
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      pwm_prev  <= 1'b1;
      seen_rise <= 1'b0;
      hi_cnt    <= '0;
      per_cnt   <= '0;
    end else begin
      pwm_prev <= pwm_level;
      if (pwm_rise) begin
        seen_rise <= 1'b1;
        per_cnt   <= PWM_CNT_W'(1);
        hi_cnt    <= PWM_CNT_W'(1);
      end else begin
        if (!per_sat) per_cnt <= per_cnt + PWM_CNT_W'(1); // RQ12
        else seen_rise <= 1'b0;
        if (pwm_level && !(&hi_cnt)) hi_cnt <= hi_cnt + PWM_CNT_W'(1); // RQ12
      end
    end
  end

  lcsd_divider #(.NUM_W(PWM_CNT_W), .Q_W(FRAC_W)) u_div (
    .clk_in      (clk_in),
    .sys_rst_in  (sys_rst_in),
    .start_in    (pwm_rise && seen_rise && !per_sat), // RQ13
    .num_in      (hi_cnt),
    .den_in      (per_cnt),
    .done_out    (div_done),
    .quotient_out(div_q)
  );

  // Static level refreshed once a millisecond while no edges arrive
  assign duty_valid = div_done || (per_sat && tick); // RQ23
  assign duty_value = div_done ? div_q : (pwm_level ? REF_FULL : '0); // RQ15

  lcsd_smooth_filter #(.W(REF_W), .K(FILTER_K), .RESET_VAL(REF_FULL)) u_filt (
    .clk_in    (clk_in),
    .sys_rst_in(sys_rst_in),
    .valid_in  (duty_valid), // RQ14
    .data_in   (duty_value),
    .data_out  (pwm_filt)
  );
  assign pwm_ratio = (pwm_filt >= DUTY_FULL_MIN) ? REF_FULL : pwm_filt; // RQ1

  // Long low level on the dim pin turns the controller off
  logic [11:0] low_ms;
  logic        pwm_disabled;
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || pwm_level) begin
      low_ms       <= 12'h000;
      pwm_disabled <= 1'b0;
    end else if (tick && !pwm_disabled) begin
      low_ms <= low_ms + 12'h001;
      if (low_ms == PWM_OFF_TICKS - 12'h001) pwm_disabled <= 1'b1; // RQ16
    end
  end

  // Dimming and compensation ratios, 4096 means full scale
  logic [21:0]      analog_dim_input_prod;
  logic [21:0]      comp_prod;
  logic [9:0]       comp_span;
  logic [REF_W-1:0] analog_dim_input_ratio;
  logic [REF_W-1:0] comp_ratio;
  logic [25:0]      dim_mix;
  logic [25:0]      sq_mix;
  logic [25:0]      ref_mix;
  logic [REF_W-1:0] dim_level;
  logic [REF_W-1:0] dim_curve;
  logic [REF_W-1:0] current_setpoint_ref;
  logic             analog_dim_input_off;
  always_comb begin
    analog_dim_input_prod = codes_in.analog_dim_input * ANALOG_DIM_INPUT_SCALE;
    comp_span = codes_in.comp - COMP_ZERO_CODE;
    comp_prod = comp_span * COMP_SCALE;
    if (codes_in.analog_dim_input < ANALOG_DIM_INPUT_MIN_CODE) analog_dim_input_ratio = ANALOG_DIM_INPUT_FLOOR; // RQ18
    else if (codes_in.analog_dim_input >= ANALOG_DIM_INPUT_FULL_CODE) analog_dim_input_ratio = REF_FULL; // RQ17
    else analog_dim_input_ratio = analog_dim_input_prod[20:8]; // RQ17
    if (codes_in.comp < COMP_ZERO_CODE) comp_ratio = '0; // RQ2
    else if (codes_in.comp >= COMP_FULL_CODE) comp_ratio = REF_FULL; // RQ2
    else comp_ratio = comp_prod[20:8];
    dim_mix   = analog_dim_input_ratio * pwm_ratio; // RQ20
    dim_level = dim_mix[24:12];
    sq_mix    = dim_level * dim_level;
    dim_curve = square_curve_in ? sq_mix[24:12] : dim_level; // RQ21
    ref_mix   = dim_curve * comp_ratio;
  end
  assign analog_dim_input_off = codes_in.analog_dim_input < ANALOG_DIM_INPUT_EN_CODE;
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) current_setpoint_ref <= '0;
    else current_setpoint_ref <= ref_mix[24:12]; // RQ1
  end
  assign current_setpoint_ref_out = current_setpoint_ref;

  // Line-shaped reference from the error integrator
  lcsd_state_type     state;
  logic [INT_W-1:0]   error_integrator;
  logic [23:0]        pf_prod;
  logic [INT_W-1:0]   power_factor_ref_signal;
  logic signed [14:0] pf_err;
  logic signed [31:0] half_acc;
  logic signed [32:0] integ_sum;
  logic [INT_W-1:0]   integ_trim;
  logic [3:0]         step_cnt;
  logic               step_en;
  logic               rec_done;
  logic               fault_trip;
  logic               uvp_trip;
  logic               short_trip;
  logic [11:0]        rec_ms;
  always_comb begin
    pf_prod                 = error_integrator * codes_in.line;
    power_factor_ref_signal = pf_prod[23:10];
    pf_err    = $signed({1'b0, power_factor_ref_signal}) - $signed({2'b00, current_setpoint_ref});
    integ_sum = $signed({19'h00000, error_integrator}) - 33'(half_acc >>> ACC_SHIFT);
    if (integ_sum < 0) integ_trim = '0;
    else if (integ_sum > $signed({19'h00000, INT_MAX})) integ_trim = INT_MAX;
    else integ_trim = integ_sum[INT_W-1:0];
  end
  assign step_en    = step_cnt == STARTUP_STEP_CYCLES - 4'h1;
  assign rec_done   = state == ST_FAULT && tick && rec_ms == RECOVERY_TICKS - 12'h001;
  assign fault_trip = state != ST_FAULT && (uvp_trip || short_trip);

  always_ff @(posedge clk_in) begin
    if (sys_rst_in || step_en) step_cnt <= 4'h0;
    else step_cnt <= step_cnt + 4'h1;
  end

  // Error summed over each half line; sign and size steer the trim
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || half_line_in || state != ST_RUN) half_acc <= '0;
    else half_acc <= half_acc + 32'(pf_err); // RQ3
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in || rec_done) begin
      error_integrator <= '0; // RQ6
    end else if (supply_restart_in && state != ST_FAULT) begin
      if (dss_option_in) error_integrator <= '0; // RQ7
    end else if (state == ST_STARTUP && step_en && codes_in.line[CODE_W-1] &&
                 power_factor_ref_signal < {1'b0, current_setpoint_ref} && error_integrator != INT_MAX) begin
      error_integrator <= error_integrator + INT_W'(1); // RQ5
    end else if (state == ST_RUN && half_line_in) begin
      error_integrator <= integ_trim; // RQ3
    end
  end

  // Operating state and auto-recovery wait
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      state <= ST_STARTUP;
    end else begin
      case (state)
        ST_STARTUP: begin
          if (fault_trip) state <= ST_FAULT;
          // Live setpoint; the register still reads zero on the first edge after reset
          else if (power_factor_ref_signal >= {1'b0, ref_mix[24:12]}) state <= ST_RUN; // RQ5
        end
        ST_RUN: begin
          if (fault_trip) state <= ST_FAULT; // RQ11
          else if (supply_restart_in) state <= ST_STARTUP;
        end
        ST_FAULT: begin
          if (rec_done) state <= ST_STARTUP; // RQ22
        end
        default: state <= ST_STARTUP;
      endcase
    end
  end
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || state != ST_FAULT) rec_ms <= 12'h000;
    else if (tick) rec_ms <= rec_ms + 12'h001; // RQ22
  end

  // Gate drive and switching permission
  logic gate;
  logic next_gate;
  logic allowed;
  logic cs_hit;
  logic gate_fall;
  assign allowed = state != ST_FAULT && !fault_trip && !pwm_disabled && !analog_dim_input_off; // RQ19
  assign cs_hit  = {1'b0, codes_in.cs, 3'h0} >= power_factor_ref_signal;
  always_comb begin
    next_gate = gate;
    if (!allowed) next_gate = 1'b0; // RQ16
    else if (gate && (cs_hit || cmp.over_limit)) next_gate = 1'b0; // RQ4
    else if (!gate && switch_start_in && !cmp.over_limit) next_gate = 1'b1;
  end
  assign gate_fall = gate && !next_gate;
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) gate <= 1'b0;
    else gate <= next_gate; // RQ9
  end
  assign gate_drive_output_out = gate;

  // Winding short watch after its own short blanking
  logic [3:0] blank_cnt;
  logic       short_flag;
  logic       short_now;
  logic [2:0] short_cnt;
  assign short_now = gate && blank_cnt == SHORT_BLANK_CYCLES && cmp.over_short; // RQ10
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || !gate) begin
      blank_cnt  <= 4'h0;
      short_flag <= 1'b0;
    end else begin
      if (blank_cnt != SHORT_BLANK_CYCLES) blank_cnt <= blank_cnt + 4'h1; // RQ10
      if (short_now) short_flag <= 1'b1;
    end
  end
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || rec_done) short_cnt <= 3'h0;
    else if (gate_fall) short_cnt <= (short_flag || short_now) ? short_cnt + 3'h1 : 3'h0; // RQ11
  end
  assign short_trip = short_cnt == SHORT_PULSES;

  // Output under-voltage timer counts only while switching is allowed
  logic [11:0] uvp_ms;
  logic        aux_seen;
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || rec_done) begin
      uvp_ms   <= 12'h000;
      aux_seen <= 1'b0;
    end else if (allowed) begin
      if (cmp.aux_above) aux_seen <= 1'b1;
      if (tick && !aux_seen && uvp_ms != UVP_TICKS) uvp_ms <= uvp_ms + 12'h001; // RQ8
    end
  end
  assign uvp_trip = uvp_ms == UVP_TICKS && !aux_seen; // RQ8

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      status_out <= '0;
    end else begin
      status_out.fault_active  <= state == ST_FAULT;
      status_out.uvp_fault     <= uvp_trip;
      status_out.short_fault   <= short_trip;
      status_out.pwm_disabled  <= pwm_disabled;
      status_out.analog_dim_input_disabled <= analog_dim_input_off;
      status_out.startup       <= state == ST_STARTUP;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  sequence short_fourth_s;
    short_cnt == 3'h3 && gate_fall && (short_flag || short_now) && state != ST_FAULT;
  endsequence
  sequence fault_entry_s;
    state != ST_FAULT ##1 state == ST_FAULT;
  endsequence

  full_ref_a : assert property ( // RQ1
    codes_in.comp >= COMP_FULL_CODE && codes_in.analog_dim_input >= ANALOG_DIM_INPUT_FULL_CODE && pwm_ratio == REF_FULL
    |=> current_setpoint_ref == REF_FULL) else $error("setpoint not full scale");
  comp_zero_a : assert property ( // RQ2
    codes_in.comp < COMP_ZERO_CODE |=> current_setpoint_ref == '0) else $error("setpoint not zero");
  cs_stop_a : assert property ( // RQ4
    gate && cs_hit |=> !gate) else $error("gate stayed on past sense level");
  limit_stop_a : assert property ( // RQ9
    gate && cmp.over_limit |=> !gate ##1 !gate) else $error("gate not cut by peak limit");
  integ_keep_a : assert property ( // RQ7
    supply_restart_in && !dss_option_in && state != ST_FAULT
    |=> error_integrator == $past(error_integrator)) else $error("integrator lost on hiccup");
  dss_clear_a : assert property ( // RQ7
    supply_restart_in && dss_option_in && state != ST_FAULT
    |=> error_integrator == '0) else $error("integrator kept with self-supply");
  integ_clear_a : assert property ( // RQ6
    rec_done |=> error_integrator == '0 && state == ST_STARTUP) else $error("no clear after fault");
  uvp_trip_a : assert property ( // RQ8
    uvp_ms == UVP_TICKS - 12'h001 && tick && allowed && !aux_seen && !cmp.aux_above
    |-> ##2 state == ST_FAULT) else $error("missed under-voltage fault");
  short_stop_a : assert property ( // RQ11
    short_fourth_s |=> ##1 state == ST_FAULT) else $error("missed winding short fault");
  analog_dim_input_off_a : assert property ( // RQ19
    analog_dim_input_off |=> !gate) else $error("gate pulse with analog dim off");
  pwm_off_a : assert property ( // RQ16
    pwm_disabled |=> !gate) else $error("gate pulse with pwm dim off");
  fault_quiet_a : assert property ( // RQ22
    fault_entry_s |-> !gate [*8]) else $error("switching during recovery");
endmodule : lcsd_setpoint_core

//--- lcsd_smooth_filter.sv
// First-order smoothing filter with a minimum step so it settles exactly
`timescale 1ns/10ps
module lcsd_smooth_filter #(
  parameter int           W         = 13,
  parameter int           K         = 3,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  input  wire logic         clk_in,
  input  wire logic         sys_rst_in,
  input  wire logic         valid_in,
  input  wire logic [W-1:0] data_in,
  output logic [W-1:0]      data_out
);
  import lcsd_pkg::*;

  logic signed [W+1:0] diff;
  logic signed [W+1:0] step;
  logic signed [W+1:0] next_y;

  always_comb begin
    diff = $signed({2'b00, data_in}) - $signed({2'b00, data_out});
    step = diff >>> K;
    // Without this the output stalls just below a rising target
    if (step == '0 && diff > '0) begin
      step = (W+2)'(1);
    end
    next_y = $signed({2'b00, data_out}) + step;
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      data_out <= RESET_VAL;
    end else if (valid_in) begin
      data_out <= next_y[W-1:0];
    end
  end
endmodule : lcsd_smooth_filter

//--- tb_top.sv
// Self-checking bench for the LED current setpoint block
`timescale 1ns/10ps
module tb_top;
  import lcsd_pkg::*;
  logic             clk_in = 1'b0;
  logic             sys_rst_in = 1'b1;
  logic             switch_start_in = 1'b0;
  logic             half_line_in = 1'b0;
  logic             square_curve_in = 1'b0;
  logic             supply_restart_in = 1'b0, dss_option_in = 1'b0;
  logic             pwm, gate;
  logic             limit_en = 1'b0, short_en = 1'b0, aux_ok = 1'b1, level = 1'b1;
  logic [7:0]       period = 8'h00, high = 8'h00;
  logic [REF_W-1:0] ref_val;
  lcsd_codes_type   codes = '{analog_dim_input: 10'h3ff, comp: 10'h3ff, line: 10'h3ff, cs: 10'h000};
  lcsd_pin_type     pins;
  lcsd_status_type  status;
  int               bad_count = 0, checks_done = 0, cycles = 0, seed = 30, h;

  initial begin
    forever #50 clk_in = ~clk_in;
  end

  lcsd_setpoint_core #(.TICK_LEN(10)) dut (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .pwm_dim_input_in(pwm), .cmp_pins_in(pins),
    .codes_in(codes), .switch_start_in(switch_start_in), .half_line_in(half_line_in),
    .supply_restart_in(supply_restart_in), .dss_option_in(dss_option_in), .square_curve_in(square_curve_in),
    .gate_drive_output_out(gate), .current_setpoint_ref_out(ref_val), .status_out(status));

  lcsd_far_side_model far (
    .clk_in(clk_in), .gate_in(gate), .period_in(period), .high_in(high), .level_in(level),
    .limit_en_in(limit_en), .short_en_in(short_en), .aux_ok_in(aux_ok), .pwm_out(pwm),
    .pins_out(pins));

  always @(negedge clk_in) begin
    cycles <= cycles + 1;
    half_line_in <= (cycles % 1000 == 999);
    if (cycles == 100000) begin
      bad_count = bad_count + 1;
      wrap_up();
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_in);
  endtask : cyc

  task automatic check_ref(input logic [REF_W-1:0] got, input logic [REF_W-1:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_ref

  task automatic check_bit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_bit

  task automatic pulse_start;
    switch_start_in = 1'b1;
    cyc(1);
    switch_start_in = 1'b0;
  endtask : pulse_start

  // Sense stays low past the short blanking, then reaches the reference
  task automatic sense_pulse;
    pulse_start();
    cyc(4);
    codes.cs = 10'h3ff;
    cyc(1);
    check_bit(gate, 1'b0);
    codes.cs = 10'h000;
    cyc(5);
  endtask : sense_pulse

  task automatic restart(input logic dynamic_self_supply);
    dss_option_in = dynamic_self_supply;
    supply_restart_in = 1'b1;
    cyc(1);
    supply_restart_in = 1'b0;
    dss_option_in = 1'b0;
    cyc(2);
  endtask : restart

  // Period of 64 keeps the expected fraction exact, no rounding
  function automatic logic [REF_W-1:0] duty_ref(input int hi, input logic sq);
    logic [REF_W-1:0] lin;
    lin = REF_W'(hi * 64);
    if (lin >= DUTY_FULL_MIN) lin = REF_FULL;
    duty_ref = sq ? REF_W'((int'(lin) * int'(lin)) >> 12) : lin;
  endfunction : duty_ref

  task automatic wrap_up;
    $display("Checks %0d, mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : wrap_up

  initial begin
    cyc(16);
    sys_rst_in = 1'b0;
    cyc(20);
    check_ref(ref_val, REF_FULL);
    check_bit(status.startup, 1'b1);
    codes.comp = 10'h07a;
    cyc(3);
    check_ref(ref_val, 13'h0000);
    codes.comp = 10'h332;
    cyc(3);
    check_ref(ref_val, REF_FULL);
    codes.analog_dim_input = 10'h048;
    cyc(3);
    check_ref(ref_val, ANALOG_DIM_INPUT_FLOOR);
    codes.analog_dim_input = 10'h300;
    cyc(3);
    check_ref(ref_val, REF_FULL);
    codes.analog_dim_input = 10'h03f;
    cyc(3);
    check_bit(status.analog_dim_input_disabled, 1'b1);
    pulse_start();
    check_bit(gate, 1'b0);
    codes.analog_dim_input = 10'h3ff;
    cyc(3);
    pulse_start();
    check_bit(gate, 1'b1);
    limit_en = 1'b1;
    cyc(4);
    check_bit(gate, 1'b0);
    limit_en = 1'b0;
    // Three random duties, one inside the full band, one at half
    period = 8'd64;
    for (int i = 0; i < 5; i++) begin
      h = (i < 3) ? 8 + int'($unsigned($random(seed)) % 49) : ((i == 3) ? 62 : 32);
      high = 8'(h);
      cyc(5000);
      check_ref(ref_val, duty_ref(h, 1'b0));
    end
    codes.analog_dim_input = 10'h180;
    cyc(3);
    check_ref(ref_val, 13'h0400);
    codes.analog_dim_input = 10'h3ff;
    cyc(3);
    square_curve_in = 1'b1;
    cyc(20);
    check_ref(ref_val, duty_ref(32, 1'b1));
    square_curve_in = 1'b0;
    check_bit(status.startup, 1'b0);
    restart(1'b0);
    check_bit(status.startup, 1'b1);
    restart(1'b1);
    period = 8'h00;
    level = 1'b0;
    cyc(300);
    check_bit(status.pwm_disabled, 1'b1);
    level = 1'b1;
    cyc(6);
    check_bit(status.pwm_disabled, 1'b0);
    short_en = 1'b1;
    repeat (4) begin
      sense_pulse();
    end
    check_bit(status.short_fault, 1'b1);
    short_en = 1'b0;
    cyc(39000);
    check_bit(status.fault_active, 1'b1);
    pulse_start();
    check_bit(gate, 1'b0);
    // Aux drops before the restart so the fresh timer never sees it high
    aux_ok = 1'b0;
    cyc(1500);
    check_bit(status.fault_active, 1'b0);
    cyc(960);
    check_bit(status.uvp_fault, 1'b1);
    wrap_up();
  end
endmodule : tb_top
